// ### inc/hobc_pkg.sv
// Constants and types for the hardware option boot configuration block.
// Assumes a 250 MHz system clock and an 8-bit register port on the core side.
package hobc_pkg;

    // Fused option word, as held in the nonvolatile option cells.
    typedef struct packed {
        logic lock;
        logic [2:0] loader_size;
        logic powerup_loader_boot_option;
        logic any_reset_loader_boot_option;
        logic [3:0] app_prog_pages;
        logic [2:0] detector2_level_select;
        logic detector1_reset_option;
        logic detector2_reset_option;
        logic watchdog_reset_option;
        logic watchdog_nonstop_option;
        logic watchdog_autostart_option;
        logic watchdog_idle_run_option;
        logic [2:0] watchdog_prescale_option;
        logic watchdog_write_protect_option;
    } hobc_opt_s;

    // Register port request, one strobe per cycle.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hobc_bus_s;

    // Debug probe commands.
    typedef enum logic [2:0] {
        DBG_RESET, DBG_RUN, DBG_STOP, DBG_STEP, DBG_CURSOR, DBG_BP_SET, DBG_BP_CLR
    } hobc_cmd_e;

    localparam int BP_NUM = 4;
    localparam int BP_IW = 2;

    typedef struct packed {
        logic vld;
        hobc_cmd_e cmd;
        logic [BP_IW-1:0] bp_idx;
        logic [12:0] addr;
    } hobc_dbg_s;

    typedef enum logic [1:0] {ST_SAMPLE, ST_APPLY, ST_RUN} hobc_state_e;

    // Register offsets.
    localparam logic [7:0] REG_DBG = 8'h00;
    localparam logic [7:0] REG_WDT = 8'h01;
    localparam logic [7:0] REG_IAP = 8'h02;
    localparam logic [7:0] REG_STAT = 8'h03;
    localparam logic [7:0] REG_OPT0 = 8'h04;
    localparam logic [7:0] REG_OPT1 = 8'h05;
    localparam logic [7:0] REG_OPT2 = 8'h06;

    // Watchdog control field positions.
    localparam int WDT_RST = 7;
    localparam int WDT_NSW = 6;
    localparam int WDT_EN = 5;
    localparam int WDT_IDL = 3;
    localparam int WDT_PS = 0;
    localparam logic [7:0] WDT_PROT_MASK = 8'hcf;
    localparam logic [7:0] WDT_RESET = 8'h00;

    // Debug control field and reset value.
    localparam int DBG_PIN_BIT = 0;
    localparam logic DBG_PIN_RESET = 1'b1;

    // Flash map.
    localparam logic [12:0] FLASH_TOP = 13'h1fff;
    localparam logic [12:0] LDR_BASE = 13'h1000;
    localparam logic [12:0] APP_START = 13'h0000;
    localparam logic [7:0] LOCK_BYTE = 8'hff;

    // Second detector level select codes and level indices.
    localparam logic [2:0] DET2_SEL_2V4 = 3'h7;
    localparam logic [2:0] DET2_SEL_3V6 = 3'h6;
    localparam logic [2:0] DET2_SEL_4V2 = 3'h5;
    localparam logic [1:0] DET2_LVL_2V4 = 2'h0;
    localparam logic [1:0] DET2_LVL_3V6 = 2'h1;
    localparam logic [1:0] DET2_LVL_4V2 = 2'h2;
    localparam logic [1:0] DET2_LVL_2V7 = 2'h3;

    // Option words after a whole erase and as shipped (1.5K loader, code 5).
    localparam hobc_opt_s OPT_ERASED = '0;
    localparam hobc_opt_s OPT_SHIPPED = 23'h280000;

endpackage : hobc_pkg

// ### design/hobc_boot_config.sv
// Hardware option boot configuration: samples fused options at power-on,
// steers boot source, brown-out and watchdog resets, debug pin sharing.
// Assumes the option cells are presented on nv_opt_in and are stable at reset.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps

module hobc_boot_config
    import hobc_pkg::*;
(
    // Clock and power-on reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // Register port.
    input wire hobc_bus_s bus_in,
    output logic [7:0] rdata_out,
    // Option cells.
    input wire hobc_opt_s nv_opt_in,
    output logic nv_wr_out,
    output hobc_opt_s nv_wdata_out,
    // External programmer.
    input wire logic prog_halt_in,
    input wire logic prog_wr_in,
    input wire logic prog_erase_in,
    input wire hobc_opt_s prog_opt_in,
    input wire logic prog_rd_in,
    input wire logic [7:0] code_byte_in,
    output logic [7:0] prog_rdata_out,
    // Debug probe and core fetch.
    input wire hobc_dbg_s dbg_in,
    input wire logic pc_vld_in,
    input wire logic [12:0] pc_in,
    output logic core_step_out,
    // Reset sources.
    input wire logic det1_low_in,
    input wire logic det2_low_in,
    input wire logic wdt_overflow_in,
    input wire logic ext_reset_in,
    // Core and peripheral controls.
    output logic core_hold_out,
    output logic core_rst_out,
    output logic boot_loader_out,
    output logic [12:0] boot_addr_out,
    output logic loader_valid_out,
    output logic [12:0] loader_start_out,
    output logic [7:0] iap_lb_out,
    output logic [1:0] det2_level_out,
    output logic [7:0] wdt_ctrl_out,
    output logic debug_sel_out
);

    hobc_state_e state_reg;
    hobc_opt_s opt_reg;
    logic [7:0] watchdog_control_reg;
    logic [7:0] app_prog_region_low_boundary;
    logic debug_pin_enable;
    logic halted_reg;
    logic [12:0] cursor_reg;
    logic cursor_arm_reg;
    logic [12:0] bp_addr_reg [BP_NUM];
    logic [BP_NUM-1:0] bp_en_reg;
    logic ldr_valid;
    logic [12:0] ldr_start;
    logic req_bod;
    logic req_any;
    logic dbg_ok;
    logic bp_hit;
    logic wr_wdt;

    // Loader region from its size code; the top is fixed at the flash end.
    assign ldr_valid = opt_reg.loader_size != 3'h0;
    assign ldr_start = LDR_BASE + 13'({opt_reg.loader_size, 9'h000});

    // Debug commands only count while the pins serve the debug path.
    assign dbg_ok = dbg_in.vld && debug_pin_enable && state_reg == ST_RUN;

    // Brown-out resets always restart the application.
    assign req_bod = (det1_low_in && opt_reg.detector1_reset_option) ||
        (det2_low_in && opt_reg.detector2_reset_option);

    // Other resets follow the any-reset boot choice.
    assign req_any = ext_reset_in || (wdt_overflow_in && watchdog_control_reg[WDT_RST]) ||
        (dbg_ok && dbg_in.cmd == DBG_RESET);

    assign wr_wdt = bus_in.wr && bus_in.addr == REG_WDT && state_reg == ST_RUN;

    // Breakpoint compare against the fetch address.
    always_comb begin
        bp_hit = cursor_arm_reg && pc_in == cursor_reg;
        for (int i = 0; i < BP_NUM; i++) begin
            if (bp_en_reg[i] && pc_in == bp_addr_reg[i]) begin
                bp_hit = 1'b1;
            end
        end
        bp_hit = bp_hit && pc_vld_in && !halted_reg;
    end

    // Start-up sequence: sample once, apply once, then run.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= ST_SAMPLE;
        end else begin
            case (state_reg)
                ST_SAMPLE: state_reg <= ST_APPLY;
                ST_APPLY: state_reg <= ST_RUN;
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_SAMPLE;
            endcase
        end
    end

    // Options are latched only here, so programming takes effect at next power-on.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            opt_reg <= OPT_SHIPPED;
        end else if (state_reg == ST_SAMPLE) begin
            opt_reg <= nv_opt_in;
        end
    end

    // Boot source and core reset pulse.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            boot_loader_out <= 1'b0;
            boot_addr_out <= APP_START;
            core_rst_out <= 1'b0;
        end else begin
            core_rst_out <= 1'b0;
            if (state_reg == ST_APPLY) begin
                boot_loader_out <= ldr_valid && (opt_reg.powerup_loader_boot_option ||
                    opt_reg.any_reset_loader_boot_option);
                boot_addr_out <= (ldr_valid && (opt_reg.powerup_loader_boot_option ||
                    opt_reg.any_reset_loader_boot_option)) ? ldr_start : APP_START;
            end else if (state_reg == ST_RUN && req_bod) begin
                core_rst_out <= 1'b1;
                boot_loader_out <= 1'b0;
                boot_addr_out <= APP_START;
            end else if (state_reg == ST_RUN && req_any) begin
                core_rst_out <= 1'b1;
                boot_loader_out <= ldr_valid && opt_reg.any_reset_loader_boot_option;
                boot_addr_out <= (ldr_valid && opt_reg.any_reset_loader_boot_option) ?
                    ldr_start : APP_START;
            end
        end
    end

    // Loader map and second detector level, fixed after apply.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            loader_valid_out <= 1'b0;
            loader_start_out <= APP_START;
            det2_level_out <= DET2_LVL_2V7;
        end else if (state_reg == ST_APPLY) begin
            loader_valid_out <= ldr_valid;
            loader_start_out <= ldr_valid ? ldr_start : APP_START;
            case (opt_reg.detector2_level_select)
                DET2_SEL_2V4: det2_level_out <= DET2_LVL_2V4;
                DET2_SEL_3V6: det2_level_out <= DET2_LVL_3V6;
                DET2_SEL_4V2: det2_level_out <= DET2_LVL_4V2;
                default: det2_level_out <= DET2_LVL_2V7;
            endcase
        end
    end

    // Watchdog control: loaded from options, then software may write it; write protect leaves only the enable bit writable.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            watchdog_control_reg <= WDT_RESET;
        end else if (state_reg == ST_APPLY) begin
            watchdog_control_reg <= WDT_RESET;
            watchdog_control_reg[WDT_RST] <= opt_reg.watchdog_reset_option;
            watchdog_control_reg[WDT_NSW] <= opt_reg.watchdog_nonstop_option;
            if (opt_reg.watchdog_autostart_option) begin
                watchdog_control_reg[WDT_EN] <= 1'b1;
                watchdog_control_reg[WDT_IDL] <= opt_reg.watchdog_idle_run_option;
                watchdog_control_reg[WDT_PS+:3] <= opt_reg.watchdog_prescale_option;
            end
        end else if (wr_wdt) begin
            if (opt_reg.watchdog_write_protect_option) begin
                watchdog_control_reg[WDT_EN] <= bus_in.wdata[WDT_EN];
            end else begin
                watchdog_control_reg <= bus_in.wdata & (WDT_PROT_MASK | 8'h20);
            end
        end
    end

    // Program region boundary: default is loader start (flash end without a loader) less app_prog_pages pages.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            app_prog_region_low_boundary <= 8'h00;
        end else if (state_reg == ST_APPLY) begin
            app_prog_region_low_boundary <= (ldr_valid ? {3'h0, ldr_start[12:8]} :
                ({3'h0, FLASH_TOP[12:8]} + 8'h01)) - {4'h0, opt_reg.app_prog_pages};
        end else if (bus_in.wr && bus_in.addr == REG_IAP && state_reg == ST_RUN) begin
            app_prog_region_low_boundary <= bus_in.wdata;
        end
    end

    // Debug pin sharing: debug function after power-on, software may release it.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            debug_pin_enable <= DBG_PIN_RESET;
        end else if (bus_in.wr && bus_in.addr == REG_DBG) begin
            debug_pin_enable <= bus_in.wdata[DBG_PIN_BIT];
        end
    end

    // Debug run control: halt, run, single step and run to cursor.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            halted_reg <= 1'b0;
            core_step_out <= 1'b0;
            cursor_reg <= APP_START;
            cursor_arm_reg <= 1'b0;
        end else begin
            core_step_out <= 1'b0;
            if (bp_hit) begin
                halted_reg <= 1'b1;
                cursor_arm_reg <= 1'b0;
            end else if (dbg_ok) begin
                case (dbg_in.cmd)
                    DBG_STOP: halted_reg <= 1'b1;
                    DBG_RUN: halted_reg <= 1'b0;
                    DBG_STEP: core_step_out <= halted_reg;
                    DBG_CURSOR: begin
                        halted_reg <= 1'b0;
                        cursor_reg <= dbg_in.addr;
                        cursor_arm_reg <= 1'b1;
                    end
                    default: halted_reg <= halted_reg;
                endcase
            end
        end
    end

    // Breakpoint table, written by the probe.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bp_en_reg <= '0;
            for (int i = 0; i < BP_NUM; i++) begin
                bp_addr_reg[i] <= APP_START;
            end
        end else if (dbg_ok && dbg_in.cmd == DBG_BP_SET) begin
            bp_en_reg[dbg_in.bp_idx] <= 1'b1;
            bp_addr_reg[dbg_in.bp_idx] <= dbg_in.addr;
        end else if (dbg_ok && dbg_in.cmd == DBG_BP_CLR) begin
            bp_en_reg[dbg_in.bp_idx] <= 1'b0;
        end
    end

    // Core hold: start-up, debug halt, or programmer holding the core.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            core_hold_out <= 1'b1;
        end else begin
            core_hold_out <= state_reg != ST_RUN || halted_reg || prog_halt_in;
        end
    end

    // Option programming has no path from the register port at all.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            nv_wr_out <= 1'b0;
            nv_wdata_out <= OPT_ERASED;
        end else begin
            nv_wr_out <= prog_halt_in && (prog_erase_in || prog_wr_in);
            if (prog_halt_in && prog_erase_in) begin
                nv_wdata_out <= OPT_ERASED;
            end else if (prog_halt_in && prog_wr_in) begin
                nv_wdata_out <= prog_opt_in;
            end
        end
    end

    // Code read-out through the programmer; lock masks every byte.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_rdata_out <= 8'h00;
        end else if (prog_rd_in) begin
            prog_rdata_out <= opt_reg.lock ? LOCK_BYTE : code_byte_in;
        end
    end

    // Register reads; unmapped offsets return zero.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                REG_DBG: rdata_out <= {7'h00, debug_pin_enable};
                REG_WDT: rdata_out <= watchdog_control_reg;
                REG_IAP: rdata_out <= app_prog_region_low_boundary;
                REG_STAT: rdata_out <= {4'h0, halted_reg, opt_reg.lock, ldr_valid,
                    boot_loader_out};
                REG_OPT0: rdata_out <= opt_reg[7:0];
                REG_OPT1: rdata_out <= opt_reg[15:8];
                REG_OPT2: rdata_out <= {1'b0, opt_reg[22:16]};
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    assign wdt_ctrl_out = watchdog_control_reg;
    assign iap_lb_out = app_prog_region_low_boundary;
    assign debug_sel_out = debug_pin_enable;

    // Checks kept beside the logic; all share the system clock and reset.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_step_req;
        dbg_ok && dbg_in.cmd == DBG_STEP && halted_reg && !bp_hit;
    endsequence

    sequence s_step_done;
        core_step_out ##1 !core_step_out && halted_reg;
    endsequence

    property p_erase;
        prog_halt_in && prog_erase_in |=> nv_wr_out && nv_wdata_out == OPT_ERASED;
    endproperty
    a_erase: assert property (p_erase) else $error("erase did not write cleared options");

    property p_lock;
        prog_rd_in && opt_reg.lock |=> prog_rdata_out == LOCK_BYTE;
    endproperty
    a_lock: assert property (p_lock) else $error("locked read returned real code");

    property p_ldr_map;
        state_reg == ST_APPLY && opt_reg.loader_size == 3'h5 |=> loader_start_out == 13'h1a00;
    endproperty
    a_ldr_map: assert property (p_ldr_map) else $error("loader start wrong");

    property p_por_boot;
        state_reg == ST_APPLY |=> boot_loader_out == (ldr_valid &&
            (opt_reg.powerup_loader_boot_option || opt_reg.any_reset_loader_boot_option));
    endproperty
    a_por_boot: assert property (p_por_boot) else $error("power-up boot source wrong");

    property p_any_boot;
        state_reg == ST_RUN && req_any && !req_bod |=> core_rst_out &&
            boot_loader_out == (ldr_valid && opt_reg.any_reset_loader_boot_option);
    endproperty
    a_any_boot: assert property (p_any_boot) else $error("reset boot source wrong");

    property p_bod;
        state_reg == ST_RUN && req_bod |=> core_rst_out && boot_addr_out == APP_START;
    endproperty
    a_bod: assert property (p_bod) else $error("brown-out reset not to application");

    property p_wdt_prot;
        wr_wdt && opt_reg.watchdog_write_protect_option |=>
            (watchdog_control_reg & WDT_PROT_MASK) == $past(watchdog_control_reg & WDT_PROT_MASK);
    endproperty
    a_wdt_prot: assert property (p_wdt_prot) else $error("protected field changed");

    property p_nv_src;
        nv_wr_out |-> $past(prog_halt_in) && $past(prog_wr_in || prog_erase_in);
    endproperty
    a_nv_src: assert property (p_nv_src) else $error("option write without programmer");

    property p_dbg_pin;
        bus_in.wr && bus_in.addr == REG_DBG |=> debug_sel_out == $past(bus_in.wdata[DBG_PIN_BIT]);
    endproperty
    a_dbg_pin: assert property (p_dbg_pin) else $error("debug pin select wrong");

    property p_step;
        s_step_req |=> s_step_done;
    endproperty
    a_step: assert property (p_step) else $error("single step not one pulse");

endmodule : hobc_boot_config

// ### tb/hobc_prog_model.sv
// Programmer and debug probe model for the boot configuration block.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/100ps
module hobc_prog_model
    import hobc_pkg::*;
(
    // Clock.
    input wire logic clk_in,
    // Programmer side.
    output logic halt_out,
    output logic wr_out,
    output logic erase_out,
    output hobc_opt_s opt_out,
    output logic rd_out,
    output logic [7:0] code_out,
    // Probe side.
    output hobc_dbg_s dbg_out
);
    // Idle lines; released option and code data flips and probe data drops its valid, so stale values never look valid.
    initial begin
        halt_out = 1'b0;
        wr_out = 1'b0;
        erase_out = 1'b0;
        opt_out = '0;
        rd_out = 1'b0;
        code_out = 8'h00;
        dbg_out = '0;
    end
    // The core stays halted for the whole programming session.
    task automatic set_halt(input logic h);
        @(posedge clk_in);
        halt_out <= h;
    endtask : set_halt
    // One whole option word written, or an erase.
    task automatic write_opt(input hobc_opt_s o, input logic er);
        @(posedge clk_in);
        wr_out <= ~er;
        erase_out <= er;
        opt_out <= o;
        @(posedge clk_in);
        wr_out <= 1'b0;
        erase_out <= 1'b0;
        opt_out <= ~o;
    endtask : write_opt
    // Code read; the flash byte is offered in the strobe cycle only.
    task automatic read_code(input logic [7:0] b);
        @(posedge clk_in);
        rd_out <= 1'b1;
        code_out <= b;
        @(posedge clk_in);
        rd_out <= 1'b0;
        code_out <= ~b;
    endtask : read_code
    // One probe command for one cycle, breakpoint slot 0 or cursor at a.
    task automatic probe(input hobc_cmd_e c, input logic [12:0] a);
        @(posedge clk_in);
        dbg_out <= {1'b1, c, 2'h0, a};
        @(posedge clk_in);
        dbg_out.vld <= 1'b0;
    endtask : probe
endmodule : hobc_prog_model

// ### tb/hobc_boot_config_test.sv
// Self-checking bench for the hardware option boot configuration block.
// Assumes the programmer model in hobc_prog_model and a 250 MHz clock.
`timescale 1ns/100ps
module hobc_boot_config_test;
    import hobc_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic det1 = 1'b0, det2 = 1'b0, ext_rst = 1'b0, wdt_ovf = 1'b0, pc_vld = 1'b0;
    hobc_bus_s bus = '0;
    hobc_opt_s nv_opt = '0, nv_wdata, p_opt;
    hobc_dbg_s dbg;
    logic halt, p_wr, p_er, p_rd, nv_wr, step, hold, crst, bldr, lvld, dsel;
    logic [7:0] code, rdata, p_rdata, iap, wdt, rd_v;
    logic [12:0] baddr, lstart;
    logic [12:0] pc = 13'h0000;
    logic [1:0] lvl;
    logic [2:0] c;
    int mismatches = 0;
    int tests_run = 0;
    // System clock, 4 ns period.
    always #2 clk_in = ~clk_in;
    // Programmer and probe.
    hobc_prog_model u_prog (.clk_in(clk_in), .halt_out(halt), .wr_out(p_wr),
        .erase_out(p_er), .opt_out(p_opt), .rd_out(p_rd), .code_out(code), .dbg_out(dbg));
    // Fetch address and watchdog overflow are driven by the main sequence.
    hobc_boot_config dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus),
        .rdata_out(rdata), .nv_opt_in(nv_opt), .nv_wr_out(nv_wr), .nv_wdata_out(nv_wdata),
        .prog_halt_in(halt), .prog_wr_in(p_wr), .prog_erase_in(p_er), .prog_opt_in(p_opt),
        .prog_rd_in(p_rd), .code_byte_in(code), .prog_rdata_out(p_rdata), .dbg_in(dbg),
        .pc_vld_in(pc_vld), .pc_in(pc), .core_step_out(step), .det1_low_in(det1),
        .det2_low_in(det2), .wdt_overflow_in(wdt_ovf), .ext_reset_in(ext_rst),
        .core_hold_out(hold), .core_rst_out(crst), .boot_loader_out(bldr),
        .boot_addr_out(baddr), .loader_valid_out(lvld), .loader_start_out(lstart),
        .iap_lb_out(iap), .det2_level_out(lvl), .wdt_ctrl_out(wdt), .debug_sel_out(dsel));
    // Four-state compare so an unknown never passes.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // One strobe cycle; read data is taken in the following cycle only.
    task automatic bus_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge clk_in);
        bus <= '0;
        #1 rd_v = rdata;
    endtask : bus_op
    // Power-on with an option word; applied values show by the third edge.
    task automatic pwr(input hobc_opt_s o);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        nv_opt <= o;
        repeat (16) @(posedge clk_in);
        chk({hold, dsel}, 2'b11);
        nrst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        #1;
    endtask : pwr
    // One-cycle reset source: 0 first detector, 1 second, 2 external, 3 watchdog.
    task automatic pulse(input int k);
        @(posedge clk_in);
        {det1, det2, ext_rst, wdt_ovf} <= 4'b1000 >> k;
        @(posedge clk_in);
        {det1, det2, ext_rst, wdt_ovf} <= 4'b0000;
        #1;
    endtask : pulse
    // Main sequence; second detector reset stays off as advised.
    initial begin
        pwr(hobc_opt_s'({1'b1, 3'h5, 2'b10, 4'h0, 3'h6, 2'b10, 4'hf, 3'h5, 1'b1}));
        chk({lvld, lstart, bldr, baddr}, {1'b1, 13'h1a00, 1'b1, 13'h1a00});
        chk({lvl, wdt, hold}, {DET2_LVL_3V6, 8'hed, 1'b0});
        chk(iap, 8'h1a);
        bus_op(1'b1, REG_OPT0, 8'h00);
        bus_op(1'b0, REG_OPT0, 8'h00);
        chk(rd_v, nv_opt[7:0]);
        bus_op(1'b1, REG_WDT, 8'h00);
        chk(wdt, 8'hcd);
        bus_op(1'b0, REG_WDT, 8'h00);
        chk(rd_v, 8'hcd);
        bus_op(1'b1, REG_IAP, 8'h12);
        bus_op(1'b0, REG_IAP, 8'h00);
        chk({rd_v, iap}, 16'h1212);
        bus_op(1'b0, 8'h20, 8'h00);
        chk(rd_v, 8'h00);
        u_prog.read_code(8'h3c);
        #1 chk(p_rdata, LOCK_BYTE);
        u_prog.write_opt(hobc_opt_s'(23'h1), 1'b0);
        #1 chk(nv_wr, 1'b0);
        u_prog.set_halt(1'b1);
        u_prog.write_opt(hobc_opt_s'(23'h1), 1'b0);
        #1 chk({nv_wr, nv_wdata}, {1'b1, 23'h1});
        u_prog.write_opt(hobc_opt_s'(23'h1), 1'b1);
        #1 chk({nv_wr, nv_wdata}, {1'b1, 23'h0});
        u_prog.set_halt(1'b0);
        u_prog.probe(DBG_STOP, 13'h0000);
        @(posedge clk_in);
        #1 chk(hold, 1'b1);
        u_prog.probe(DBG_STEP, 13'h0000);
        #1 chk(step, 1'b1);
        u_prog.probe(DBG_RUN, 13'h0000);
        repeat (2) @(posedge clk_in);
        #1 chk(hold, 1'b0);
        bus_op(1'b1, REG_DBG, 8'h00);
        chk(dsel, 1'b0);
        u_prog.probe(DBG_STOP, 13'h0000);
        repeat (2) @(posedge clk_in);
        #1 chk(hold, 1'b0);
        bus_op(1'b1, REG_DBG, 8'h01);
        chk(dsel, 1'b1);
        pulse(0);
        chk({crst, baddr}, {1'b1, APP_START});
        pulse(1);
        chk(crst, 1'b0);
        pulse(2);
        chk({crst, bldr}, 2'b10);
        pulse(3);
        chk({crst, bldr}, 2'b10);
        // A breakpoint, then a run-to-cursor target, each halts the core when fetched.
        u_prog.probe(DBG_BP_SET, 13'h0123);
        for (int k = 0; k < 2; k++) begin
            {pc_vld, pc} <= {1'b1, k ? 13'h0044 : 13'h0123};
            repeat (3) @(posedge clk_in);
            pc_vld <= 1'b0;
            #1 chk(hold, 1'b1);
            u_prog.probe(DBG_CURSOR, 13'h0044);
            repeat (2) @(posedge clk_in);
            #1 chk(hold, 1'b0);
        end
        // Loader size and detector level codes 1 to 7, power-up boot off.
        for (int i = 1; i < 8; i++) begin
            c = 3'(i);
            pwr(hobc_opt_s'({1'b0, c, 6'h0, c, 10'h0}));
            chk({lvld, lstart, bldr}, {1'b1, 13'h1000 + {c, 9'h0}, 1'b0});
            chk(lvl, (c == 3'h7) ? DET2_LVL_2V4 : (c == 3'h6) ? DET2_LVL_3V6 :
                (c == 3'h5) ? DET2_LVL_4V2 : DET2_LVL_2V7);
        end
        pwr(hobc_opt_s'({1'b0, 3'h5, 2'b01, 17'h0}));
        chk({bldr, baddr}, {1'b1, 13'h1a00});
        pulse(2);
        chk({crst, bldr}, 2'b11);
        pwr(OPT_ERASED);
        chk({lvld, bldr, wdt}, 10'h0);
        u_prog.read_code(8'h3c);
        #1 chk(p_rdata, 8'h3c);
        pulse(0);
        chk(crst, 1'b0);
        pulse(3);
        chk(crst, 1'b0);
        end_sim();
    end
    // Hang guard.
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule : hobc_boot_config_test
